// >>> pabm_pin_mux.v
// Purpose: Pin function selection for port A and port B, port B registers
// Assumes: Timer and pattern control bits arrive from on-chip logic on clk
// Notes: Pin input levels are synchronised before any use
`timescale 1ns/10ps
`include "pabm_map.vh"
module pabm_pin_mux #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire hw_standby,
    input wire expanded_mode,
    input wire [2:0] pulse_width_mode,
    input wire phase_count_flag,
    input wire [8:0] a_pin_io_select,
    input wire [8:0] b_pin_io_select,
    input wire [8:0] prescaler_select,
    input wire [11:0] byte_timer_clock_select,
    input wire [3:0] byte_timer_out_active,
    input wire [3:0] byte_timer_out_val,
    input wire [1:0] capture_input_enable,
    input wire [3:0] chip_sel_enable,
    input wire [3:0] chip_sel_n,
    input wire [2:0] ch_a_out,
    input wire [2:0] ch_b_out,
    input wire [15:0] pattern_enable,
    input wire [15:0] pattern_out_bit,
    input wire [7:0] port_a_direction,
    input wire [7:0] port_a_latch,
    input wire [3:0] addr_hi,
    input wire [2:0] addr_enable_n,
    input wire [W-1:0] pa_in,
    output reg [W-1:0] pa_out,
    output reg [W-1:0] pa_oe,
    input wire [W-1:0] pb_in,
    output reg [W-1:0] pb_out,
    output reg [W-1:0] pb_oe,
    output wire [2:0] ch_a_capture,
    output wire [2:0] ch_b_capture,
    output wire [3:0] ext_clock_in,
    output wire [1:0] byte_timer_capture,
    input wire [`PABM_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PABM_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    reg [W-1:0] pa_s1_r, pa_s2_r, pb_s1_r, pb_s2_r;
    reg [W-1:0] pb_dir_r, pb_latch_r;
    reg [`PABM_ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_full_r, w_full_r;
    integer i;
    integer j;

    always @(posedge clk) begin
        pa_s1_r <= pa_in;
        pa_s2_r <= pa_s1_r;
        pb_s1_r <= pb_in;
        pb_s2_r <= pb_s1_r;
    end

    // AXI write: address and data latched independently, then one response
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    wire do_write = aw_full_r && w_full_r && !s_axi_bvalid;
    wire [`PABM_ADDR_W-1:0] wword = awaddr_r & `PABM_WORD_MASK;
    wire hit_dir_w = (wword == (`PABM_OFS_PB_DIR & `PABM_WORD_MASK));
    wire hit_lat_w = (wword == (`PABM_OFS_PB_LATCH & `PABM_WORD_MASK));
    // Byte lane holding the register's low 8 bits
    wire [`PABM_ADDR_W-1:0] dir_ofs = `PABM_OFS_PB_DIR;
    wire [`PABM_ADDR_W-1:0] lat_ofs = `PABM_OFS_PB_LATCH;
    wire [1:0] dir_lane = dir_ofs[1:0];
    wire [1:0] lat_lane = lat_ofs[1:0];
    wire [7:0] dir_wbyte = wdata_r[{dir_lane, 3'b000} +: 8];
    wire [7:0] lat_wbyte = wdata_r[{lat_lane, 3'b000} +: 8];

    always @(posedge clk) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= {`PABM_ADDR_W{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PABM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (hit_dir_w || hit_lat_w) ? `PABM_RESP_OKAY : `PABM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Registers hold through software standby; only reset or hard standby clear them
    always @(posedge clk) begin
        if (rst) begin
            pb_dir_r <= `PABM_PB_RESET;
            pb_latch_r <= `PABM_PB_RESET;
        end else if (hw_standby) begin
            pb_dir_r <= `PABM_PB_RESET;
            pb_latch_r <= `PABM_PB_RESET;
        end else if (do_write) begin
            if (hit_dir_w && wstrb_r[dir_lane])
                pb_dir_r <= dir_wbyte;
            if (hit_lat_w && wstrb_r[lat_lane])
                pb_latch_r <= lat_wbyte;
        end
    end

    // AXI read
    assign s_axi_arready = !s_axi_rvalid;
    wire [`PABM_ADDR_W-1:0] rword = s_axi_araddr & `PABM_WORD_MASK;
    wire hit_dir_r = (rword == (`PABM_OFS_PB_DIR & `PABM_WORD_MASK));
    wire hit_lat_r = (rword == (`PABM_OFS_PB_LATCH & `PABM_WORD_MASK));
    wire [7:0] lat_read = (pb_dir_r & pb_latch_r) | (~pb_dir_r & pb_s2_r);

    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PABM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PABM_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (hit_dir_r)
                s_axi_rdata <= {24'h000000, `PABM_DIR_READ} << {dir_lane, 3'b000};
            else if (hit_lat_r)
                s_axi_rdata <= {24'h000000, lat_read} << {lat_lane, 3'b000};
            else
                s_axi_rresp <= `PABM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Timer claim decode per 16-bit channel
    wire [2:0] a_claim, b_claim;
    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1) begin : g_ch
            wire [2:0] fa = a_pin_io_select[3*c +: 3];
            wire [2:0] fb = b_pin_io_select[3*c +: 3];
            assign a_claim[c] = pulse_width_mode[c] ||
                (!fa[`PABM_IO_TOP] && (fa != 3'h0));
            assign b_claim[c] = !fb[`PABM_IO_TOP] && (fb != 3'h0);
        end
    endgenerate

    // Channel c pins: A on PA(2c+2)... map: ch0 A=PA2 B=PA3, ch1 A=PA4 B=PA5, ch2 A=PA6 B=PA7
    assign ch_a_capture[0] = a_pin_io_select[2] & pa_s2_r[2];
    assign ch_a_capture[1] = a_pin_io_select[5] & pa_s2_r[4];
    assign ch_a_capture[2] = a_pin_io_select[8] & pa_s2_r[6];
    assign ch_b_capture[0] = b_pin_io_select[2] & !pulse_width_mode[0] & pa_s2_r[3];
    assign ch_b_capture[1] = b_pin_io_select[5] & !pulse_width_mode[1] & pa_s2_r[5];
    assign ch_b_capture[2] = b_pin_io_select[8] & !pulse_width_mode[2] & pa_s2_r[7];

    // External clock routing
    wire [3:0] psc_hit;
    wire [3:0] cks_hit;
    assign psc_hit[0] = (prescaler_select[2:0] == `PABM_PSC_A) ||
        (prescaler_select[5:3] == `PABM_PSC_A) || (prescaler_select[8:6] == `PABM_PSC_A);
    assign psc_hit[1] = (prescaler_select[2:0] == `PABM_PSC_B) ||
        (prescaler_select[5:3] == `PABM_PSC_B) || (prescaler_select[8:6] == `PABM_PSC_B);
    assign psc_hit[2] = (prescaler_select[2:0] == `PABM_PSC_C) ||
        (prescaler_select[5:3] == `PABM_PSC_C) || (prescaler_select[8:6] == `PABM_PSC_C);
    assign psc_hit[3] = (prescaler_select[2:0] == `PABM_PSC_D) ||
        (prescaler_select[5:3] == `PABM_PSC_D) || (prescaler_select[8:6] == `PABM_PSC_D);
    // Byte timer select slices: [2:0]=ch0 [5:3]=ch1 [8:6]=ch2 [11:9]=ch3
    assign cks_hit[0] = byte_timer_clock_select[5:3] >= `PABM_CKS_EXT_MIN;
    assign cks_hit[1] = byte_timer_clock_select[11:9] >= `PABM_CKS_EXT_MIN;
    assign cks_hit[2] = byte_timer_clock_select[2:0] >= `PABM_CKS_EXT_MIN;
    assign cks_hit[3] = byte_timer_clock_select[8:6] >= `PABM_CKS_EXT_MIN;
    assign ext_clock_in[0] = (phase_count_flag | psc_hit[0] | cks_hit[0]) & pa_s2_r[0];
    assign ext_clock_in[1] = (phase_count_flag | psc_hit[1] | cks_hit[1]) & pa_s2_r[1];
    assign ext_clock_in[2] = (psc_hit[2] | cks_hit[2]) & pa_s2_r[2];
    assign ext_clock_in[3] = (psc_hit[3] | cks_hit[3]) & pa_s2_r[3];

    assign byte_timer_capture[0] = capture_input_enable[0] & pb_s2_r[1];
    assign byte_timer_capture[1] = capture_input_enable[1] & pb_s2_r[3];

    // Port A pin functions, combinational from selection bits
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            pa_oe[i] = port_a_direction[i];
            pa_out[i] = pattern_enable[i] ? pattern_out_bit[i] : port_a_latch[i];
        end
        for (i = 0; i < 3; i = i + 1) begin
            if (a_claim[i]) begin
                pa_oe[2*i+2] = 1'b1;
                pa_out[2*i+2] = ch_a_out[i];
            end
            if (b_claim[i]) begin
                pa_oe[2*i+3] = 1'b1;
                pa_out[2*i+3] = ch_b_out[i];
            end
        end
        if (expanded_mode) begin
            pa_oe[7] = 1'b1;
            pa_out[7] = addr_hi[0];
            for (i = 0; i < 3; i = i + 1) begin
                if (!addr_enable_n[i]) begin
                    pa_oe[6-i] = 1'b1;
                    pa_out[6-i] = addr_hi[i+1];
                end
            end
        end
    end

    // Port B pin functions; direction kept through software standby keeps outputs up
    always @* begin
        for (j = 0; j < 8; j = j + 1) begin
            pb_oe[j] = pb_dir_r[j];
            pb_out[j] = pattern_enable[8+j] ? pattern_out_bit[8+j] : pb_latch_r[j];
        end
        for (j = 0; j < 4; j = j + 1) begin
            if (byte_timer_out_active[j]) begin
                pb_oe[j] = 1'b1;
                pb_out[j] = byte_timer_out_val[j];
            end else if (chip_sel_enable[3-j]) begin
                pb_oe[j] = 1'b1;
                pb_out[j] = chip_sel_n[3-j];
            end
        end
    end
endmodule // pabm_pin_mux

// >>> pabm_map.vh
// Purpose: Register map and field constants for the port A/B pin function mux
// Assumes: AXI4-Lite byte addressing, one aligned 32-bit word per register
// Notes: Behaviour
`ifndef PABM_MAP_VH
`define PABM_MAP_VH
`define PABM_ADDR_W 20
`define PABM_OFS_PB_DIR 20'hee00a
`define PABM_OFS_PB_LATCH 20'hfffda
`define PABM_WORD_MASK 20'hffffc
`define PABM_PB_RESET 8'h00
`define PABM_DIR_READ 8'hff
`define PABM_IO_TOP 2
`define PABM_PSC_D 3'h7
`define PABM_PSC_C 3'h6
`define PABM_PSC_B 3'h5
`define PABM_PSC_A 3'h4
`define PABM_CKS_EXT_MIN 3'h5
`define PABM_RESP_OKAY 2'h0
`define PABM_RESP_SLVERR 2'h2
`endif

// >>> pabm_monitor.sv
// Purpose: Port checks for the port A/B pin mux
// Assumes: Bound to pabm_pin_mux, single clock domain
// Notes: Pin outputs are combinational, so they are sampled at each edge
`timescale 1ns/10ps
module pabm_monitor #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire expanded_mode,
    input wire [3:0] addr_hi,
    input wire [2:0] addr_enable_n,
    input wire [W-1:0] pa_out,
    input wire [W-1:0] pa_oe,
    input wire [15:0] pattern_enable,
    input wire [15:0] pattern_out_bit,
    input wire [W-1:0] pb_out,
    input wire [W-1:0] pb_oe,
    input wire [3:0] byte_timer_out_active,
    input wire [3:0] byte_timer_out_val,
    input wire [3:0] chip_sel_enable,
    input wire [3:0] chip_sel_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [19:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    pa7_addr20_a: assert property (expanded_mode |-> pa_oe[7] && pa_out[7] == addr_hi[0])
        else $error("pa7 not driving address bit 20");
    pa6_addr21_a: assert property (expanded_mode && !addr_enable_n[0] |-> pa_oe[6] && pa_out[6] == addr_hi[1])
        else $error("pa6 not driving address bit 21");
    pb_pattern_a: assert property (((pb_out[7:4] ^ pattern_out_bit[15:12]) & pb_oe[7:4] & pattern_enable[15:12]) == 4'h0)
        else $error("pattern bit not on port b pin");
    pb3_timer_a: assert property (byte_timer_out_active[3] |-> pb_oe[3] && pb_out[3] == byte_timer_out_val[3])
        else $error("pb3 timer output lost");
    pb3_csel_a: assert property (!byte_timer_out_active[3] && chip_sel_enable[0] |-> pb_oe[3] && pb_out[3] == chip_sel_n[0])
        else $error("pb3 chip select output lost");
    pb0_timer_a: assert property (byte_timer_out_active[0] |-> pb_oe[0] && pb_out[0] == byte_timer_out_val[0])
        else $error("pb0 timer output lost");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after request");
    dir_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 20'hee008 |=> s_axi_rvalid && s_axi_rdata == 32'h00ff0000)
        else $error("direction read not all ones");
    cover property (expanded_mode && !addr_enable_n[0]);
    cover property (byte_timer_out_active[3] && chip_sel_enable[0]);
    cover property (s_axi_bvalid);
endmodule // pabm_monitor

// >>> pabm_pins_model.sv
// Purpose: Board pins and wiring beside the port A/B pin mux
// Assumes: No pull resistors, undriven pins follow the board levels
// Notes: A driven pin reads back its own driven level
`timescale 1ns/10ps
module pabm_pins_model (
    input wire [7:0] pa_oe,
    input wire [7:0] pa_out,
    input wire [7:0] pb_oe,
    input wire [7:0] pb_out,
    input wire [7:0] pa_ext,
    input wire [7:0] pb_ext,
    output wire [7:0] pa_in,
    output wire [7:0] pb_in
);
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
endmodule // pabm_pins_model

// >>> test_port_a_b_pin_function_mux.sv
// Purpose: Register and pin function checks for the port A/B pin mux
// Assumes: Word-aligned bus addresses, register byte in lane 2
// Notes: Pin inputs pass two sync flops, so routed levels are read late
`timescale 1ns/10ps
`include "pabm_map.vh"
module test_port_a_b_pin_function_mux;
    logic clk, rst, hw_standby, expanded_mode, phase_count_flag;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] capture_input_enable, s_axi_bresp, s_axi_rresp, byte_timer_capture, rs;
    logic [2:0] pulse_width_mode, ch_a_out, ch_b_out, addr_enable_n, ch_a_capture, ch_b_capture;
    logic [3:0] byte_timer_out_active, byte_timer_out_val, chip_sel_enable, chip_sel_n, addr_hi;
    logic [3:0] ext_clock_in, s_axi_wstrb, e;
    logic [7:0] port_a_direction, port_a_latch, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic [7:0] pa_ext, pb_ext, rd;
    logic [8:0] a_pin_io_select, b_pin_io_select, prescaler_select;
    logic [11:0] byte_timer_clock_select;
    logic [11:0] btc [4] = '{12'h028, 12'hc00, 12'h007, 12'h140};
    logic [15:0] pattern_enable, pattern_out_bit;
    logic [19:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int bad_count, n_checks, i;
    pabm_pin_mux dut (.*);
    pabm_pins_model u_pins (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Ready is judged mid-cycle: inputs only move after rising edges
    task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d,
                       input logic [1:0] er);
        logic t, ha, hw, hr;
        int n;
        t = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a & `PABM_WORD_MASK;
        s_axi_araddr <= a & `PABM_WORD_MASK;
        s_axi_wdata <= {8'h00, d, 16'h0000};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (n = 0; n < 40 && !t; n++) begin
            @(negedge clk);
            {ha, hw, hr} = {s_axi_awready, s_axi_wready, s_axi_arready};
            t = w ? s_axi_bvalid : s_axi_rvalid;
            rs = w ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata[23:16];
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hr) s_axi_arvalid <= 1'b0;
            if (t) {s_axi_bready, s_axi_rready} <= 2'b00;
        end
        chk(rs, er);
        if (!t) begin
            bad_count++;
            $display("FAIL %0t bus timeout", $time);
            stop_test;
        end
    endtask
    initial begin
        {hw_standby, expanded_mode, phase_count_flag, capture_input_enable, pulse_width_mode} = '0;
        {ch_a_out, ch_b_out, byte_timer_out_active, byte_timer_out_val, chip_sel_enable} = '0;
        {port_a_direction, port_a_latch, a_pin_io_select, b_pin_io_select, prescaler_select} = '0;
        {byte_timer_clock_select, pattern_enable, pattern_out_bit, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
        {clk, rst, s_axi_wstrb, chip_sel_n, addr_hi, addr_enable_n, pa_ext, pb_ext} =
            {2'b01, 4'hf, 4'h5, 4'h0, 3'h7, 8'h4f, 8'h3c};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(0, `PABM_OFS_PB_DIR, 8'h00, `PABM_RESP_OKAY);
        chk({pb_oe, rd}, {8'h00, `PABM_DIR_READ});
        acc(0, `PABM_OFS_PB_LATCH, 8'h00, `PABM_RESP_OKAY);
        chk(rd, pb_ext);
        acc(1, `PABM_OFS_PB_LATCH, 8'h5a, `PABM_RESP_OKAY);
        // Pass 0 under hard standby: writes lost, latch cleared; pass 1 after it
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            hw_standby <= !i;
            acc(1, `PABM_OFS_PB_DIR, 8'hff, `PABM_RESP_OKAY);
            acc(0, `PABM_OFS_PB_LATCH, 8'h00, `PABM_RESP_OKAY);
            chk({pb_oe, rd}, i ? {8'hff, `PABM_PB_RESET} : {8'h00, pb_ext});
        end
        acc(1, `PABM_OFS_PB_LATCH, 8'ha5, `PABM_RESP_OKAY);
        chk({pb_oe, pb_out}, 16'hffa5);
        acc(1, `PABM_OFS_PB_DIR, 8'h0f, `PABM_RESP_OKAY);
        acc(1, 20'h00010, 8'hff, `PABM_RESP_SLVERR);
        acc(0, 20'h00020, 8'h00, `PABM_RESP_SLVERR);
        acc(0, `PABM_OFS_PB_LATCH, 8'h00, `PABM_RESP_OKAY);
        chk(rd, 8'h35);
        acc(1, `PABM_OFS_PB_DIR, 8'hff, `PABM_RESP_OKAY);
        pattern_enable <= 16'hf000;
        pattern_out_bit <= 16'h6000;
        @(negedge clk);
        chk({pb_oe, pb_out}, 16'hff65);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            chip_sel_enable <= 4'h8 >> i;
            @(negedge clk);
            e = 4'ha >> i;
            chk({pb_oe[i], pb_out[i]}, {1'b1, e[0]});
            @(posedge clk);
            byte_timer_out_active <= 4'h1 << i;
            byte_timer_out_val <= 4'h5;
            @(negedge clk);
            chk({pb_oe[i], pb_out[i]}, {1'b1, !e[0]});
        end
        @(posedge clk);
        {expanded_mode, addr_hi, addr_enable_n, pulse_width_mode, ch_a_out} <=
            {1'b1, 4'h5, 3'h6, 3'h4, 3'h4};
        @(negedge clk);
        chk({pa_oe[7:6], pa_out[7:6]}, 4'he);
        @(posedge clk);
        addr_enable_n <= 3'h7;
        @(negedge clk);
        chk({pa_oe[7:6], pa_out[7:6]}, 4'hf);
        @(posedge clk);
        {expanded_mode, pulse_width_mode, a_pin_io_select} <= 13'h0100;
        {capture_input_enable, byte_timer_out_active} <= 6'h30;
        b_pin_io_select <= 9'h004;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({pa_oe[6], ch_a_capture[2], byte_timer_capture, ch_b_capture}, 7'h31);
        for (i = 0; i < 9; i++) begin
            @(posedge clk);
            prescaler_select <= (i < 4) ? {3'h0, 3'h4 + 3'(i), 3'h0} : 9'h000;
            byte_timer_clock_select <= (i > 3 && i < 8) ? btc[i - 4] : 12'h000;
            phase_count_flag <= (i == 8);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(ext_clock_in, (i == 8) ? 4'h3 : 4'h1 << (i % 4));
        end
        @(posedge clk);
        {port_a_direction, port_a_latch, pattern_enable} <= {8'h03, 8'h03, 16'hf002};
        pulse_width_mode <= 3'h1;
        @(negedge clk);
        chk({pa_oe[2:0], pa_out[1:0], ch_b_capture[0]}, 6'h3a);
        stop_test;
    end
endmodule // test_port_a_b_pin_function_mux
bind pabm_pin_mux pabm_monitor #(.W(W)) u_mon (.*);
